// ---- rtl/vec_unit_map.svh ----
`ifndef VEC_UNIT_MAP_SVH
`define VEC_UNIT_MAP_SVH

`define VEC_PRIMARY_OPCODE 6'h0A
`define VEC_PRIMARY_HI 31
`define VEC_PRIMARY_LO 26
`define VEC_DEST_HI 25
`define VEC_DEST_LO 21
`define VEC_SRC1_HI 20
`define VEC_SRC1_LO 16
`define VEC_SRC2_HI 15
`define VEC_SRC2_LO 11
`define VEC_SUB_HI 7
`define VEC_SUB_LO 0
`define VEC_SUB_PACK_HS 8'h63
`define VEC_SUB_PACK_BU 8'h64
`define VEC_SUB_PACK_HU 8'h65
`define VEC_SUB_PERM_N 8'h66
`define VEC_SUB_ROT_B 8'h67
`define VEC_SUB_ROT_H 8'h68
`define VEC_DATA_RESET 64'h0000_0000_0000_0000
`define VEC_HIGH_HALF_LSB 32

`endif

// ---- rtl/vec_unit_pkg.sv ----
package vec_unit_pkg;
  typedef enum logic [2:0] {
    OP_NONE,
    OP_HALF_PACK_SIGNED_SAT,
    OP_BYTE_PACK_UNSIGNED_SAT,
    OP_HALF_PACK_UNSIGNED_SAT,
    OP_NIBBLE_PERMUTE,
    OP_BYTE_ROTATE_LEFT,
    OP_HALF_ROTATE_LEFT
  } vec_op_t;
endpackage : vec_unit_pkg

// ---- rtl/vec_issue_if.sv ----
`timescale 1ns/1ns
interface vec_issue_if;
  import vec_unit_pkg::*;
  logic valid;
  vec_op_t op;
  logic [4:0] dest;
  logic [63:0] first_source;
  logic [63:0] second_source;
  modport decoder (output valid, output op, output dest, output first_source, output second_source);
  modport datapath (input valid, input op, input dest, input first_source, input second_source);
endinterface : vec_issue_if

// ---- rtl/vec_decode.sv ----
`timescale 1ns/1ns
`include "vec_unit_map.svh"
module vec_decode
  import vec_unit_pkg::*;
(
  // issue side
  input wire logic issue_valid,
  input wire logic [31:0] instr,
  input wire logic [63:0] first_source,
  input wire logic [63:0] second_source,
  // to datapath
  vec_issue_if.decoder dec
);
  // bits 10:8 are never looked at
  function automatic vec_op_t decode_sub(input logic [7:0] sub);
    case (sub)
      `VEC_SUB_PACK_HS: decode_sub = OP_HALF_PACK_SIGNED_SAT;
      `VEC_SUB_PACK_BU: decode_sub = OP_BYTE_PACK_UNSIGNED_SAT;
      `VEC_SUB_PACK_HU: decode_sub = OP_HALF_PACK_UNSIGNED_SAT;
      `VEC_SUB_PERM_N: decode_sub = OP_NIBBLE_PERMUTE;
      `VEC_SUB_ROT_B: decode_sub = OP_BYTE_ROTATE_LEFT;
      `VEC_SUB_ROT_H: decode_sub = OP_HALF_ROTATE_LEFT;
      default: decode_sub = OP_NONE;
    endcase
  endfunction : decode_sub

  logic hit_primary;
  vec_op_t op_sel;
  assign hit_primary = instr[`VEC_PRIMARY_HI:`VEC_PRIMARY_LO] == `VEC_PRIMARY_OPCODE;
  assign op_sel = hit_primary ? decode_sub(instr[`VEC_SUB_HI:`VEC_SUB_LO]) : OP_NONE;
  assign dec.valid = issue_valid && (op_sel != OP_NONE);
  assign dec.op = op_sel;
  assign dec.dest = instr[`VEC_DEST_HI:`VEC_DEST_LO];
  assign dec.first_source = first_source;
  assign dec.second_source = second_source;
endmodule : vec_decode

// ---- rtl/vec_pack_permute_rotate.sv ----
`timescale 1ns/1ns
`include "vec_unit_map.svh"
module vec_pack_permute_rotate
  import vec_unit_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // issue
  input wire logic issue_valid_i,
  input wire logic [31:0] instr_i,
  input wire logic [63:0] first_source_i,
  input wire logic [63:0] second_source_i,
  // write-back
  output logic wb_valid_o,
  output logic [4:0] wb_dest_o,
  output logic [63:0] wb_data_o
);
  vec_issue_if dec_bus ();

  vec_decode u_decode (
    .issue_valid(issue_valid_i),
    .instr(instr_i),
    .first_source(first_source_i),
    .second_source(second_source_i),
    .dec(dec_bus.decoder)
  );

  function automatic logic [7:0] clamp_signed_to_byte(input logic [15:0] v);
    if (!v[15] && (v[14:7] != 8'h00)) begin
      clamp_signed_to_byte = 8'h7F;
    end else if (v[15] && (v[14:7] != 8'hFF)) begin
      clamp_signed_to_byte = 8'h80;
    end else begin
      clamp_signed_to_byte = v[7:0];
    end
  endfunction : clamp_signed_to_byte

  function automatic logic [7:0] clamp_unsigned_to_byte(input logic [15:0] v);
    clamp_unsigned_to_byte = (v[15:8] != 8'h00) ? 8'hFF : v[7:0];
  endfunction : clamp_unsigned_to_byte

  function automatic logic [3:0] clamp_unsigned_to_nibble(input logic [7:0] v);
    clamp_unsigned_to_nibble = (v[7:4] != 4'h0) ? 4'hF : v[3:0];
  endfunction : clamp_unsigned_to_nibble

  logic [63:0] first_source;
  logic [63:0] second_source;
  assign first_source = dec_bus.first_source;
  assign second_source = dec_bus.second_source;

  logic [63:0] half_pack_signed;
  logic [63:0] half_pack_unsigned;
  logic [63:0] byte_pack_unsigned;
  logic [63:0] nibble_permute;
  logic [63:0] byte_rotate;
  logic [63:0] half_rotate;

  genvar gi;
  // halfword packs and rotate: four elements per source
  generate
    for (gi = 0; gi < 4; gi++) begin : g_half
      logic [31:0] dbl;
      logic [31:0] shifted;
      assign half_pack_signed[gi*8 +: 8] = clamp_signed_to_byte(second_source[gi*16 +: 16]);
      assign half_pack_signed[`VEC_HIGH_HALF_LSB + gi*8 +: 8] =
        clamp_signed_to_byte(first_source[gi*16 +: 16]);
      assign half_pack_unsigned[gi*8 +: 8] = clamp_unsigned_to_byte(second_source[gi*16 +: 16]);
      assign half_pack_unsigned[`VEC_HIGH_HALF_LSB + gi*8 +: 8] =
        clamp_unsigned_to_byte(first_source[gi*16 +: 16]);
      // double the element then take the upper copy for a rotate
      assign dbl = {first_source[gi*16 +: 16], first_source[gi*16 +: 16]};
      assign shifted = dbl << second_source[gi*16 +: 4];
      assign half_rotate[gi*16 +: 16] = shifted[31:16];
    end
  endgenerate

  // byte ops: eight elements per source
  generate
    for (gi = 0; gi < 8; gi++) begin : g_byte
      logic [15:0] dbl;
      logic [15:0] shifted;
      assign byte_pack_unsigned[gi*4 +: 4] = clamp_unsigned_to_nibble(second_source[gi*8 +: 8]);
      assign byte_pack_unsigned[`VEC_HIGH_HALF_LSB + gi*4 +: 4] =
        clamp_unsigned_to_nibble(first_source[gi*8 +: 8]);
      assign dbl = {first_source[gi*8 +: 8], first_source[gi*8 +: 8]};
      assign shifted = dbl << second_source[gi*8 +: 3];
      assign byte_rotate[gi*8 +: 8] = shifted[15:8];
    end
  endgenerate

  // nibble permute: a 16-way select per result nibble
  generate
    for (gi = 0; gi < 16; gi++) begin : g_perm
      logic [3:0] idx;
      assign idx = second_source[gi*4 +: 4];
      assign nibble_permute[gi*4 +: 4] = first_source[{idx, 2'b00} +: 4];
    end
  endgenerate

  logic [63:0] next_data;
  always_comb begin
    case (dec_bus.op)
      OP_HALF_PACK_SIGNED_SAT: next_data = half_pack_signed;
      OP_BYTE_PACK_UNSIGNED_SAT: next_data = byte_pack_unsigned;
      OP_HALF_PACK_UNSIGNED_SAT: next_data = half_pack_unsigned;
      OP_NIBBLE_PERMUTE: next_data = nibble_permute;
      OP_BYTE_ROTATE_LEFT: next_data = byte_rotate;
      OP_HALF_ROTATE_LEFT: next_data = half_rotate;
      default: next_data = `VEC_DATA_RESET;
    endcase
  end

  // one result stage; no exception path exists by design
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      wb_valid_o <= 1'b0;
    end else begin
      wb_valid_o <= dec_bus.valid;
    end
  end

  // data held when nothing issues, so write-back sees stable value
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      wb_data_o <= `VEC_DATA_RESET;
      wb_dest_o <= 5'h00;
    end else if (dec_bus.valid) begin
      wb_data_o <= next_data;
      wb_dest_o <= dec_bus.dest;
    end
  end
endmodule : vec_pack_permute_rotate

// ---- sim/gpr_writeback_model.sv ----
`timescale 1ns/1ns
module gpr_writeback_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // write-back port
  input wire logic wb_valid_i,
  output int writes_o
);
  // counts retired results, restarting with every reset
  always_ff @(posedge clk_i) begin
    writes_o <= srst_i ? 0 : writes_o + int'(wb_valid_i);
  end
endmodule : gpr_writeback_model

// ---- sim/vec_ppr_chk.sv ----
`timescale 1ns/1ns
module vec_ppr_chk (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic issue_valid_i,
  input wire logic [31:0] instr_i,
  input wire logic [63:0] first_source_i,
  input wire logic [63:0] second_source_i,
  input wire logic wb_valid_o,
  input wire logic [4:0] wb_dest_o,
  input wire logic [63:0] wb_data_o
);
  localparam logic [63:0] C = 64'h8000_7FFF_0080_FF7F;
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  logic go;
  logic [7:0] sub;
  assign sub = instr_i[7:0];
  assign go = issue_valid_i && instr_i[31:26] == 6'h0A && sub >= 8'h63 && sub <= 8'h68;
  taken_pulse_a: assert property (go |=> wb_valid_o) else $error("no write-back");
  refused_quiet_a: assert property (!go |=> !wb_valid_o) else $error("stray write-back");
  dest_capture_a: assert property (go |=> wb_dest_o == $past(instr_i[25:21])) else $error("bad dest");
  // the reset edge itself clears data, so skip the edge after it
  data_hold_a: assert property (!wb_valid_o && !$past(srst_i) |-> $stable(wb_data_o)) else $error("data moved");
  pack_signed_a: assert property (go && sub == 8'h63 && second_source_i == C
    |=> wb_data_o[31:0] == 32'h807F_7F80) else $error("signed pack");
  pack_nibble_a: assert property (go && sub == 8'h64 && second_source_i == C
    |=> wb_data_o[31:0] == 32'hF0FF_0FFF) else $error("nibble pack");
  pack_unsigned_a: assert property (go && sub == 8'h65 && second_source_i == C
    |=> wb_data_o[31:0] == 32'hFFFF_80FF) else $error("unsigned pack");
  perm_ident_a: assert property (go && sub == 8'h66 && second_source_i == 64'hFEDC_BA98_7654_3210
    |=> wb_data_o == $past(first_source_i)) else $error("permute");
  rot_zero_a: assert property (go && sub inside {8'h67, 8'h68} && second_source_i == '0
    |=> wb_data_o == $past(first_source_i)) else $error("rotate");
endmodule : vec_ppr_chk
bind vec_pack_permute_rotate vec_ppr_chk vec_ppr_chk_inst (.clk_i, .srst_i, .issue_valid_i, .instr_i,
  .first_source_i, .second_source_i, .wb_valid_o, .wb_dest_o, .wb_data_o);

// ---- sim/tb_top.sv ----
`timescale 1ns/1ns
module tb_top;
  logic clk_i = 0, srst_i = 1, issue_valid_i = 0, wb_valid_o, ev = 0;
  logic [31:0] instr_i = '0;
  logic [63:0] first_source_i = '0, second_source_i = '0, ed = '0, wb_data_o;
  logic [4:0] wb_dest_o, edst = '0;
  int mismatches = 0, comparisons = 0, n_wb = 0, writes;
  always #25 clk_i = ~clk_i;
  vec_pack_permute_rotate vec_pack_permute_rotate_inst (.clk_i(clk_i), .srst_i(srst_i),
    .issue_valid_i(issue_valid_i), .instr_i(instr_i), .first_source_i(first_source_i),
    .second_source_i(second_source_i), .wb_valid_o(wb_valid_o), .wb_dest_o(wb_dest_o), .wb_data_o(wb_data_o));
  gpr_writeback_model gpr_writeback_model_inst (.clk_i(clk_i), .srst_i(srst_i), .wb_valid_i(wb_valid_o),
    .writes_o(writes));
  function automatic logic [63:0] calc(input logic [7:0] op, input logic [63:0] a, input logic [63:0] b);
    logic [63:0] r;
    logic signed [15:0] h;
    r = '0;
    for (int k = 0; k < 16; k++) begin
      case (op)
        8'h63, 8'h65: if (k < 8) begin
          h = k < 4 ? b[k*16+:16] : a[(k-4)*16+:16];
          if (op == 8'h63) r[k*8+:8] = h > 127 ? 8'h7F : h < -128 ? 8'h80 : h[7:0];
          else r[k*8+:8] = h[15:8] != 8'h00 ? 8'hFF : h[7:0];
        end
        8'h64: begin
          h = {8'h00, k < 8 ? b[k*8+:8] : a[(k-8)*8+:8]};
          r[k*4+:4] = h > 15 ? 4'hF : h[3:0];
        end
        8'h66: r[k*4+:4] = a[b[k*4+:4]*4+:4];
        8'h67: if (k < 8) begin
          r[k*8+:8] = (a[k*8+:8] << b[k*8+:3]) | (a[k*8+:8] >> (4'd8 - b[k*8+:3]));
        end
        8'h68: if (k < 4) begin
          r[k*16+:16] = (a[k*16+:16] << b[k*16+:4]) | (a[k*16+:16] >> (5'd16 - b[k*16+:4]));
        end
        default: r = r;
      endcase
    end
    return r;
  endfunction : calc
  function automatic logic [63:0] pick(input int unsigned s);
    logic [63:0] t[6] = '{64'h0, '1, 64'h8000_7FFF_0080_FF7F, 64'hFEDC_BA98_7654_3210, 64'h0F10_FE01_3210_7654,
      64'h0};
    return s % 6 == 5 ? {$urandom, $urandom} : t[s % 6];
  endfunction : pick
  task chk(input string nm, input logic [63:0] e, input logic [63:0] s);
    comparisons++;
    if (e !== s) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  initial begin
    #100000;
    mismatches++;
    give_verdict();
  end
  initial begin
    void'($urandom(32'h0e06bdb1));
    repeat (10) @(posedge clk_i);
    #5 srst_i = 0;
    for (int i = 0; i <= 800; i++) begin
      @(posedge clk_i);
      #5;
      chk("valid", 64'(ev), 64'(wb_valid_o));
      chk("dest", 64'(edst), 64'(wb_dest_o));
      chk("data", ed, wb_data_o);
      // a second reset mid-run must clear the write-back side
      srst_i = i == 400;
      // no issue in the cycle leaving reset, none in the closing pass
      issue_valid_i = !(i inside {401, 800}) && $urandom % 5 != 0;
      instr_i = {$urandom % 8 == 0 ? 6'($urandom) : 6'h0A, 5'($urandom), 13'($urandom), 8'h61 + 8'($urandom % 10)};
      first_source_i = pick($urandom);
      second_source_i = pick($urandom);
      ev = !srst_i && issue_valid_i && instr_i[31:26] == 6'h0A && instr_i[7:0] inside {[8'h63:8'h68]};
      if (srst_i) {ed, edst, n_wb} = '0;
      else if (ev) begin
        ed = calc(instr_i[7:0], first_source_i, second_source_i);
        edst = instr_i[25:21];
        n_wb++;
      end
    end
    @(posedge clk_i);
    #5;
    chk("writes", 64'(n_wb), 64'(writes));
    give_verdict();
  end
endmodule : tb_top
